// file: design/ipcb_defines.vh
// Register offsets, field positions and reset values for the priority bank.
`ifndef IPCB_DEFINES_VH
`define IPCB_DEFINES_VH

// ==========================================================================
// Register byte offsets on the register bus
// ==========================================================================
`define IPCB_OFS_CTRL_1   6'h00
`define IPCB_OFS_CTRL_2   6'h04
`define IPCB_OFS_CTRL_3   6'h08
`define IPCB_OFS_PEND     6'h0C
`define IPCB_OFS_WINNER   6'h10
`define IPCB_ADDR_W       6

// ==========================================================================
// Field layout inside one byte lane of a priority register
// ==========================================================================
`define IPCB_PRI_HI       4
`define IPCB_PRI_LO       2
`define IPCB_SUB_HI       1
`define IPCB_SUB_LO       0
`define IPCB_LANE_MASK    8'h1F
`define IPCB_CTRL1_MASK   32'h00001F1F
`define IPCB_CTRL_MASK    32'h1F1F1F1F

// ==========================================================================
// Reset values and bus answers
// ==========================================================================
`define IPCB_CTRL_RESET   32'h00000000
`define IPCB_PRI_OFF      3'h0
`define IPCB_RESP_OKAY    2'h0
`define IPCB_RESP_SLVERR  2'h2
`define IPCB_SOURCES      8

`endif

// file: design/ipcb_arbiter.v
// Picks the winning pending source from priority and subpriority fields.
`timescale 1ns/10ps
`default_nettype none
`include "ipcb_defines.vh"

module ipcb_arbiter #(
   parameter N = 8                          // Number of sources.
) (
   input  wire [N-1:0]   i_pending,         // Raw pending request per source.
   input  wire [3*N-1:0] i_priority,        // Packed 3-bit priorities.
   input  wire [2*N-1:0] i_subpriority,     // Packed 2-bit subpriorities.
   output reg            o_valid,           // A source is requested.
   output reg  [2:0]     o_index,           // Winning source index.
   output reg  [2:0]     o_level,           // Winning priority level.
   output reg  [1:0]     o_sublevel         // Winning subpriority level.
);

   integer     k;
   reg  [4:0]  best;
   reg  [4:0]  cand;

   // ========================================================================
   // Linear scan; ties of full key go to the lowest index for determinism.
   // ========================================================================
   always @* begin
      best       = 5'h00;
      cand       = 5'h00;
      o_valid    = 1'b0;
      o_index    = 3'h0;
      o_level    = 3'h0;
      o_sublevel = 2'h0;
      for (k = 0; k < N; k = k + 1) begin
         cand = {i_priority[3*k +: 3], i_subpriority[2*k +: 2]};
         // Zero priority masks the source completely.
         if (i_pending[k] && (i_priority[3*k +: 3] != `IPCB_PRI_OFF) &&
             (!o_valid || (cand > best))) begin
            best       = cand;
            o_valid    = 1'b1;
            o_index    = k[2:0];
            o_level    = cand[4:2];
            o_sublevel = cand[1:0];
         end
      end
   end

endmodule // ipcb_arbiter
`default_nettype wire

// file: design/ipcb_priority_bank.v
// AXI4-Lite priority configuration bank for eight interrupt sources.
// Functional notes
// - A source whose 3-bit priority is zero is disabled, never requested.
// - A nonzero priority value is used directly as the level 1 to 7.
// - Each source has a 2-bit subpriority whose value is its level 0-3.
// - Register 2 holds ext irq 2 priority 28:26, subpriority 25:24.
// - Register 2 holds compare 2 priority 20:18, subpriority 17:16.
// - Register 2 holds capture 2 priority 12:10, subpriority 9:8.
// - Register 2 holds timer 2 priority 4:2, subpriority 1:0.
// - Register 3 repeats it for ext irq 3, compare 3, capture 3, timer 3.
// - Register 1 low half holds capture 1 at 12:8 and timer 1 at 4:0.
// - All fields are read/write and clear to zero on reset.
`timescale 1ns/10ps
`default_nettype none
`include "ipcb_defines.vh"

module ipcb_priority_bank (
   input  wire        i_clock,         // System clock, 200 MHz.
   input  wire        i_arst_n,        // Asynchronous reset, active low.
   input  wire [5:0]  i_awaddr,        // Write address.
   input  wire        i_awvalid,       // Write address valid.
   output wire        o_awready,       // Write address ready.
   input  wire [31:0] i_wdata,         // Write data.
   input  wire [3:0]  i_wstrb,         // Write byte strobes.
   input  wire        i_wvalid,        // Write data valid.
   output wire        o_wready,        // Write data ready.
   output reg  [1:0]  o_bresp,         // Write response.
   output reg         o_bvalid,        // Write response valid.
   input  wire        i_bready,        // Write response ready.
   input  wire [5:0]  i_araddr,        // Read address.
   input  wire        i_arvalid,       // Read address valid.
   output wire        o_arready,       // Read address ready.
   output reg  [31:0] o_rdata,         // Read data.
   output reg  [1:0]  o_rresp,         // Read response.
   output reg         o_rvalid,        // Read data valid.
   input  wire        i_rready,        // Read data ready.
   input  wire [7:0]  i_irq_pending,   // Pending flags, same clock domain.
   output reg         o_irq_request,   // A source is requested to the core.
   output reg  [2:0]  o_irq_index,     // Winning source index.
   output reg  [2:0]  o_irq_level,     // Winning priority level.
   output reg  [1:0]  o_irq_sublevel   // Winning subpriority level.
);

   // ========================================================================
   // Storage and internal nets
   // ========================================================================
   reg  [31:0] ctrl_1;
   reg  [31:0] ctrl_2;
   reg  [31:0] ctrl_3;
   reg  [5:0]  aw_addr;
   reg         aw_held;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         w_held;
   reg  [31:0] next_rdata;
   reg  [1:0]  next_rresp;
   wire        do_write;
   wire        do_read;
   wire [23:0] pri_bus;
   wire [15:0] sub_bus;
   wire        arb_valid;
   wire [2:0]  arb_index;
   wire [2:0]  arb_level;
   wire [1:0]  arb_sublevel;

   // Merges strobed bytes and clears bits that do not exist.
   function [31:0] merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0]  strb;
      input [31:0] mask;
      integer      b;
      begin
         merge = old_val;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[8*b +: 8] = new_val[8*b +: 8];
            end
         end
         merge = merge & mask;
      end
   endfunction

   // Extracts the priority field from one byte lane.
   function [2:0] lane_pri;
      input [31:0] r;
      input [1:0]  lane;
      begin
         lane_pri = r[8*lane + `IPCB_PRI_LO +: 3];
      end
   endfunction

   // Extracts the subpriority field from one byte lane.
   function [1:0] lane_sub;
      input [31:0] r;
      input [1:0]  lane;
      begin
         lane_sub = r[8*lane + `IPCB_SUB_LO +: 2];
      end
   endfunction

   // ========================================================================
   // Write channel: address and data are captured in either order.
   // ========================================================================
   assign o_awready = !aw_held && !o_bvalid;
   assign o_wready  = !w_held && !o_bvalid;
   assign do_write  = aw_held && w_held && !o_bvalid;

   // Holding registers let the master release each channel independently.
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         aw_held <= 1'b0;
         aw_addr <= 6'h00;
         w_held  <= 1'b0;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Register update and write answer; all fields clear on reset.
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_1   <= `IPCB_CTRL_RESET;
         ctrl_2   <= `IPCB_CTRL_RESET;
         ctrl_3   <= `IPCB_CTRL_RESET;
         o_bvalid <= 1'b0;
         o_bresp  <= `IPCB_RESP_OKAY;
      end else begin
         if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp  <= `IPCB_RESP_OKAY;
            case (aw_addr)
               `IPCB_OFS_CTRL_1: begin
                  // Upper half of register 1 lies outside this bank.
                  ctrl_1 <= merge(ctrl_1, w_data, w_strb,
                                  `IPCB_CTRL1_MASK);
               end
               `IPCB_OFS_CTRL_2: begin
                  // Four lanes of priority/subpriority.
                  ctrl_2 <= merge(ctrl_2, w_data, w_strb,
                                  `IPCB_CTRL_MASK);
               end
               `IPCB_OFS_CTRL_3: begin
                  ctrl_3 <= merge(ctrl_3, w_data, w_strb,
                                  `IPCB_CTRL_MASK);
               end
               `IPCB_OFS_PEND, `IPCB_OFS_WINNER: begin
                  // Status words are read-only; writes are dropped quietly.
                  o_bresp <= `IPCB_RESP_OKAY;
               end
               default: begin
                  o_bresp <= `IPCB_RESP_SLVERR;
               end
            endcase
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // ========================================================================
   // Read channel: one read in flight, answered the cycle after acceptance.
   // ========================================================================
   assign o_arready = !o_rvalid;
   assign do_read   = i_arvalid && o_arready;

   // Read decode; reserved and absent bits read as zero.
   always @* begin
      next_rresp = `IPCB_RESP_OKAY;
      case (i_araddr)
         `IPCB_OFS_CTRL_1: next_rdata = ctrl_1;
         `IPCB_OFS_CTRL_2: next_rdata = ctrl_2;
         `IPCB_OFS_CTRL_3: next_rdata = ctrl_3;
         `IPCB_OFS_PEND:   next_rdata = {24'h000000, i_irq_pending};
         `IPCB_OFS_WINNER: next_rdata = {23'h000000, o_irq_request,
                                         o_irq_index, o_irq_level,
                                         o_irq_sublevel};
         default: begin
            next_rdata = 32'h00000000;
            next_rresp = `IPCB_RESP_SLVERR;
         end
      endcase
   end

   // Read data stands until the master takes it.
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h00000000;
         o_rresp  <= `IPCB_RESP_OKAY;
      end else begin
         if (do_read) begin
            o_rvalid <= 1'b1;
            o_rdata  <= next_rdata;
            o_rresp  <= next_rresp;
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // ========================================================================
   // Field routing to the eight pending slots of the arbiter.
   // ========================================================================
   // Slot order from 0: timer2, capture1, capture2, capture3, compare2,
   // ext_irq2, compare3, ext_irq3. The timer 1 and timer 3 fields are
   // stored and read back, but they have no pending slot in this bank.
   assign pri_bus = {lane_pri(ctrl_3, 2'd3),   // 7 ext_irq3
                     lane_pri(ctrl_3, 2'd2),   // 6 compare3
                     lane_pri(ctrl_2, 2'd3),   // 5 ext_irq2
                     lane_pri(ctrl_2, 2'd2),   // 4 compare2
                     lane_pri(ctrl_3, 2'd1),   // 3 capture3
                     lane_pri(ctrl_2, 2'd1),   // 2 capture2
                     lane_pri(ctrl_1, 2'd1),   // 1 capture1
                     lane_pri(ctrl_2, 2'd0)};  // 0 timer2
   assign sub_bus = {lane_sub(ctrl_3, 2'd3),
                     lane_sub(ctrl_3, 2'd2),
                     lane_sub(ctrl_2, 2'd3),
                     lane_sub(ctrl_2, 2'd2),
                     lane_sub(ctrl_3, 2'd1),
                     lane_sub(ctrl_2, 2'd1),
                     lane_sub(ctrl_1, 2'd1),
                     lane_sub(ctrl_2, 2'd0)};

   ipcb_arbiter #(
      .N             (`IPCB_SOURCES)
   ) u_arbiter (
      .i_pending     (i_irq_pending),
      .i_priority    (pri_bus),
      .i_subpriority (sub_bus),
      .o_valid       (arb_valid),
      .o_index       (arb_index),
      .o_level       (arb_level),
      .o_sublevel    (arb_sublevel)
   );

   // Winner is registered so the core sees glitch-free outputs.
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_irq_request  <= 1'b0;
         o_irq_index    <= 3'h0;
         o_irq_level    <= 3'h0;
         o_irq_sublevel <= 2'h0;
      end else begin
         o_irq_request  <= arb_valid;
         o_irq_index    <= arb_index;
         o_irq_level    <= arb_level;
         o_irq_sublevel <= arb_sublevel;
      end
   end

endmodule // ipcb_priority_bank
`default_nettype wire

// file: tb/ipcb_monitor.sv
// Concurrent checks on the priority bank's bus and winner outputs.
`timescale 1ns/10ps
`default_nettype none
`include "ipcb_defines.vh"
module ipcb_monitor (
   input wire logic        i_clock,        // System clock.
   input wire logic        i_arst_n,       // Reset, active low.
   input wire logic        i_awvalid,      // Write address valid.
   input wire logic        o_awready,      // Write address ready.
   input wire logic        i_wvalid,       // Write data valid.
   input wire logic        o_wready,       // Write data ready.
   input wire logic        o_bvalid,       // Write response valid.
   input wire logic [1:0]  o_bresp,        // Write response.
   input wire logic        i_bready,       // Write response ready.
   input wire logic [5:0]  i_araddr,       // Read address.
   input wire logic        i_arvalid,      // Read address valid.
   input wire logic        o_arready,      // Read address ready.
   input wire logic [31:0] o_rdata,        // Read data.
   input wire logic [1:0]  o_rresp,        // Read response.
   input wire logic        o_rvalid,       // Read data valid.
   input wire logic        i_rready,       // Read data ready.
   input wire logic [7:0]  i_irq_pending,  // Pending flags.
   input wire logic        o_irq_request,  // Request to the core.
   input wire logic [2:0]  o_irq_level     // Winning level.
);
   // ======================================================================
   // Checks
   // ======================================================================
   // Every check shares one clock and is quiet while reset is held.
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   a_request_has_level: assert property (
      o_irq_request |-> o_irq_level != 3'h0)
      else $error("request raised with a zero level");
   a_idle_no_request: assert property (
      $past(i_irq_pending) == 8'h00 |-> !o_irq_request)
      else $error("request raised with nothing pending");
   a_read_answer: assert property (
      i_arvalid && o_arready |=> o_rvalid)
      else $error("read not answered one cycle after the address");
   a_rdata_holds: assert property (
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped before it was taken");
   a_bresp_holds: assert property (
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped before it was taken");
   a_write_answer: assert property (
      i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
      else $error("write response late");
   a_read_blocks_addr: assert property (
      o_rvalid |-> !o_arready)
      else $error("read address taken while data waits");
   a_write_blocks_addr: assert property (
      o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while a response waits");
   a_unmapped_read: assert property (
      i_arvalid && o_arready && i_araddr >= 6'h14 |=>
      o_rresp == `IPCB_RESP_SLVERR && o_rdata == 32'h0)
      else $error("unmapped read not refused");
   // Coverage of the main traffic.
   c_write_done: cover property (o_bvalid && i_bready);
   c_read_refused: cover property (o_rvalid && o_rresp == `IPCB_RESP_SLVERR);
   c_top_level: cover property (o_irq_request && o_irq_level == 3'h7);
endmodule // ipcb_monitor
bind ipcb_priority_bank ipcb_monitor u_mon (
   .i_clock(i_clock), .i_arst_n(i_arst_n),
   .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
   .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
   .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
   .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
   .o_rvalid(o_rvalid), .i_rready(i_rready), .i_irq_pending(i_irq_pending),
   .o_irq_request(o_irq_request), .o_irq_level(o_irq_level));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the interrupt priority configuration bank.
`timescale 1ns/10ps
`default_nettype none
`include "ipcb_defines.vh"
module testbench;
   logic        i_clock = 1'h0, i_arst_n = 1'h0;
   logic [5:0]  i_awaddr = 6'h00, i_araddr = 6'h00;
   logic [31:0] i_wdata = 32'h0, rd, win;
   logic [3:0]  i_wstrb = 4'h0;
   logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
   logic        i_arvalid = 1'h0, i_rready = 1'h0;
   logic [7:0]  i_irq_pending = 8'h00;
   logic [1:0]  resp;
   wire logic   o_awready, o_wready, o_bvalid, o_arready;
   wire logic   o_rvalid, o_irq_request;
   wire logic [1:0]  o_bresp, o_rresp, o_irq_sublevel;
   wire logic [2:0]  o_irq_index, o_irq_level;
   wire logic [31:0] o_rdata;
   int          num_errors = 0, total_checks = 0;
   // Period of 5 ns for the 200 MHz system clock.
   always #2.5 i_clock = ~i_clock;
   ipcb_priority_bank dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
      .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
      .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
      .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
      .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .o_rvalid(o_rvalid), .i_rready(i_rready), .i_irq_pending(i_irq_pending),
      .o_irq_request(o_irq_request), .o_irq_index(o_irq_index),
      .o_irq_level(o_irq_level), .o_irq_sublevel(o_irq_sublevel));
   // ======================================================================
   // Bus and compare helpers
   // ======================================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Ready goes up late on purpose so the slave must hold its answer.
   task automatic bus_write(input logic [5:0] a, input logic [31:0] d,
                            input logic [3:0] s);
      int n;
      @(posedge i_clock);
      n = 0;
      i_awaddr  <= a;
      i_wdata   <= d;
      i_wstrb   <= s;
      i_awvalid <= 1'h1;
      i_wvalid  <= 1'h1;
      while (1'h1) begin
         @(posedge i_clock);
         n++;
         if (o_awready) i_awvalid <= 1'h0;
         if (o_wready) i_wvalid <= 1'h0;
         if (n == 3) i_bready <= 1'h1;
         if (o_bvalid && i_bready) break;
      end
      resp = o_bresp;
      i_bready <= 1'h0;
   endtask
   task automatic bus_read(input logic [5:0] a);
      int n;
      @(posedge i_clock);
      n = 0;
      i_araddr  <= a;
      i_arvalid <= 1'h1;
      while (1'h1) begin
         @(posedge i_clock);
         n++;
         if (o_arready) i_arvalid <= 1'h0;
         if (n == 2) i_rready <= 1'h1;
         if (o_rvalid && i_rready) break;
      end
      rd = o_rdata;
      resp = o_rresp;
      i_rready <= 1'h0;
   endtask
   // Winner outputs trail the pending flags by one edge, so wait two.
   task automatic win_sample(input logic [7:0] pend);
      @(posedge i_clock);
      i_irq_pending <= pend;
      repeat (2) @(posedge i_clock);
      win = {23'h0, o_irq_request, o_irq_index, o_irq_level, o_irq_sublevel};
   endtask
   // ======================================================================
   // Scenarios
   // ======================================================================
   task automatic t_reset_fields();
      for (int r = 0; r < 3; r++) begin
         bus_read(6'(r * 4));
         check(rd, `IPCB_CTRL_RESET);
      end
      win_sample(8'hFF);
      check(win, 32'h0);
      $display("test reset fields done");
   endtask
   // Reserved bits are only ever written as zero, and ignored on read.
   task automatic t_layout();
      logic [31:0] m;
      for (int r = 0; r < 3; r++) begin
         m = (r == 0) ? `IPCB_CTRL1_MASK : `IPCB_CTRL_MASK;
         bus_write(6'(r * 4), m, 4'hF);
         bus_read(6'(r * 4));
         check(rd & m, m);
         bus_write(6'(r * 4), 32'h0, 4'hF);
      end
      $display("test layout done");
   endtask
   task automatic t_levels();
      for (int v = 0; v < 32; v++) begin
         bus_write(`IPCB_OFS_CTRL_2, 32'(v), 4'hF);
         win_sample(8'h01);
         if (v[4:2] == 3'h0) check(win & 32'h100, 32'h0);
         else check(win, {23'h0, 1'h1, 3'h0, v[4:0]});
      end
      $display("test levels done");
   endtask
   // Register holding each source slot, and the lane shift of its field.
   task automatic t_mapping();
      int rg[8] = '{2, 1, 2, 3, 2, 2, 3, 3};
      int sh[8] = '{0, 8, 8, 8, 16, 24, 16, 24};
      bus_write(`IPCB_OFS_CTRL_2, 32'h0, 4'hF);
      for (int k = 0; k < 8; k++) begin
         bus_write(6'((rg[k] - 1) * 4), 32'h16 << sh[k], 4'hF);
         win_sample(8'hFF);
         check(win, 32'h116 | (k << 5));
         bus_write(6'((rg[k] - 1) * 4), 32'h0, 4'hF);
      end
      $display("test mapping done");
   endtask
   task automatic t_arbitration();
      bus_write(`IPCB_OFS_CTRL_2, 32'h1D1F1B00, 4'hF);
      win_sample(8'h34);
      check(win, 32'h19F);
      bus_write(`IPCB_OFS_CTRL_2, 32'h0, 4'h4);
      bus_read(`IPCB_OFS_CTRL_2);
      check(rd, 32'h1D001B00);
      win_sample(8'h34);
      check(win, 32'h1BD);
      bus_write(`IPCB_OFS_CTRL_2, 32'h0, 4'hF);
      $display("test arbitration done");
   endtask
   // Status words follow the pins and the winner; a write to the pending word is dropped.
   task automatic t_status();
      bus_write(`IPCB_OFS_CTRL_3, 32'h00140000, 4'hF);
      check({30'h0, resp}, {30'h0, `IPCB_RESP_OKAY});
      win_sample(8'h45);
      check(win, 32'h1D4);
      bus_read(`IPCB_OFS_PEND);
      check({30'h0, resp}, {30'h0, `IPCB_RESP_OKAY});
      check(rd, 32'h45);
      bus_read(`IPCB_OFS_WINNER);
      check(rd, 32'h1D4);
      bus_write(`IPCB_OFS_PEND, 32'hFFFFFFFF, 4'hF);
      check({30'h0, resp}, {30'h0, `IPCB_RESP_OKAY});
      bus_read(`IPCB_OFS_CTRL_3);
      check(rd, 32'h00140000);
      bus_write(`IPCB_OFS_CTRL_3, 32'h0, 4'hF);
      $display("test status done");
   endtask
   task automatic t_unmapped();
      bus_write(6'h20, 32'h1F, 4'hF);
      check({30'h0, resp}, {30'h0, `IPCB_RESP_SLVERR});
      bus_read(6'h20);
      check({30'h0, resp}, {30'h0, `IPCB_RESP_SLVERR});
      check(rd, 32'h0);
      $display("test unmapped done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence, and a watchdog far beyond the expected few microseconds.
   initial begin
      repeat (5) @(posedge i_clock);
      i_arst_n <= 1'h1;
      t_reset_fields();
      t_layout();
      t_levels();
      t_mapping();
      t_arbitration();
      t_status();
      t_unmapped();
      print_verdict();
   end
   initial begin
      #50000;
      num_errors++;
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
